//--- logic/pac_defs.vh
// How it works
// - power budget is always reported as zero watts.
// - power dissipation is always reported as zero watts.
// - device specific init option advertises an init sequence after uninitialized D0.
// - D1 and D2 support advertised only when their options are set.
// - PME support set decides in which power states wake may be asserted.
// - no soft reset is unsupported; D3hot to D0 always resets internally.
// - virtual channel and vendor capabilities exist only with serial number on.
// - root port with snoop reject may refuse clear no-snoop requests as UR.
// - vendor capability exposes registers including a loopback control.
// - on endpoints, user legacy config enabled forwards requests beyond built-in range to user.
// - legacy config start dword pointer is limited to 2Ah through 3Fh.
// - on endpoints, user extended config enabled forwards dword addresses at or above pointer.
// - digest trimming strips digest and clears digest bit before delivery.
// - endpoint message routing also passes Unlock and PME_Turn_Off.
// - root port message routing also passes error, INTx, PM_PME, PME_TO_ACK.
// - buffer pipelining is on write path only or on read and write.
// - ack latency override combines with built-in by absolute, add or subtract.
// - replay timer override combines with built-in by absolute, add or subtract.
// - forced no scrambling turns the scramblers off, diagnostics only.
// - upconfigure advertised only when selected; lane reversal only when set.
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH
`define PAC_A_CTRL 8'h00
`define PAC_A_PMCAP 8'h04
`define PAC_A_LEGPTR 8'h08
`define PAC_A_EXTPTR 8'h0C
`define PAC_A_ACKOVR 8'h10
`define PAC_A_RPLOVR 8'h14
`define PAC_A_TMR 8'h18
`define PAC_A_LINK 8'h1C
`define PAC_A_DSNLO 8'h20
`define PAC_A_DSNHI 8'h24
`define PAC_A_STAT 8'h28
`define PAC_CTRL_RST 32'h0040_0000
`define PAC_CTRL_MASK 32'h03FF_FEFF
`define PAC_B_DSI 0
`define PAC_B_D1 1
`define PAC_B_D2 2
`define PAC_F_PME 7:3
`define PAC_B_DSN 9
`define PAC_B_VC 10
`define PAC_B_VSEC 11
`define PAC_B_ROOT 12
`define PAC_B_REJSN 13
`define PAC_B_LEGEN 14
`define PAC_B_EXTEN 15
`define PAC_B_TRIM 16
`define PAC_B_MSGRT 17
`define PAC_F_PIPE 19:18
`define PAC_B_LREV 20
`define PAC_B_NOSCR 21
`define PAC_B_UPCFG 22
`define PAC_B_L0SDIS 23
`define PAC_B_DOWN 24
`define PAC_B_LOOP 25
`define PAC_PIPE_WR 2'h1
`define PAC_LEG_MIN 6'h2A
`define PAC_LEG_MAX 6'h3F
`define PAC_EXT_MIN 10'h040
`define PAC_EXT_RST 10'h100
`define PAC_ZERO_W 8'h00
`define PAC_FN_ABS 2'h0
`define PAC_FN_ADD 2'h1
`define PAC_FN_SUB 2'h2
`define PAC_ACK_BASE 15'h0021
`define PAC_RPL_BASE 15'h0064
`define PAC_D0 2'h0
`define PAC_D1 2'h1
`define PAC_D2 2'h2
`define PAC_D3 2'h3
`define PAC_B_TD 15
`define PAC_B_NS 12
`define PAC_F_TYPE 28:24
`define PAC_T_MRD 5'h00
`define PAC_T_MRDLK 5'h01
`define PAC_MSG_HI 2'h2
`define PAC_M_UNLOCK 8'h00
`define PAC_M_PM_PME 8'h18
`define PAC_M_TURNOFF 8'h19
`define PAC_M_TOACK 8'h1B
`define PAC_M_INT_LO 8'h20
`define PAC_M_INT_HI 8'h27
`define PAC_M_ERRCOR 8'h30
`define PAC_M_ERRNF 8'h31
`define PAC_M_ERRF 8'h33
`endif

//--- logic/pac_attr_ctrl.v
`timescale 1ns/10ps
`include "pac_defs.vh"
module pac_attr_ctrl (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [63:0] i_dsn,
  input wire [1:0] i_pm_state,
  input wire i_pme_req,
  input wire i_dsi_done,
  output reg o_power_wake_request_out,
  output reg o_pm_internal_rst,
  output reg o_dsi_seq_req,
  output reg [7:0] o_power_budget,
  output reg [7:0] o_power_dissipated,
  output reg o_dsn_cap_present,
  output reg o_vc_cap_present,
  output reg o_vsec_cap_present,
  output reg o_loopback_en,
  input wire i_cfg_vld,
  input wire [9:0] i_cfg_dw_addr,
  output reg o_cfg_vld,
  output reg o_cfg_to_user,
  input wire i_rx_vld,
  input wire [31:0] i_rx_dw0,
  input wire [7:0] i_rx_msg_code,
  input wire [10:0] i_rx_len_dw,
  output reg o_rx_vld,
  output reg [31:0] o_rx_dw0,
  output reg [10:0] o_rx_len_dw,
  output reg o_rx_deliver,
  output reg o_rx_ur,
  output reg o_buf_wr_pipe,
  output reg o_buf_rd_pipe,
  input wire [3:0] i_neg_width,
  input wire [2:0] i_mps,
  output reg [14:0] o_ack_timeout,
  output reg [14:0] o_replay_timeout,
  output reg o_lane_rev_en,
  output reg o_scramble_dis,
  output reg o_upcfg_capable,
  input wire i_tx_l0s_req,
  output reg o_tx_l0s_enter,
  output reg [7:0] o_ts_link_num,
  output reg o_ts_link_num_vld
);

  reg [31:0] ctrl_r;
  reg [5:0] leg_ptr_r;
  reg [9:0] ext_ptr_r;
  reg [18:0] ack_ovr_r;
  reg [18:0] rpl_ovr_r;
  reg [7:0] link_num_r;
  reg [1:0] pm_prev_r;
  reg [31:0] rd_nxt;
  reg [31:0] wr_nxt;
  reg [5:0] leg_nxt;
  reg [9:0] ext_nxt;
  reg [31:0] ext_mrg;
  reg [31:0] ack_mrg;
  reg [31:0] rpl_mrg;
  reg [14:0] ack_base;
  reg [14:0] rpl_base;
  reg pme_ok;
  reg msg_pass;
  wire [7:0] byte_adr;
  wire wb_req;
  wire [4:0] rx_type;
  wire rx_is_msg;
  wire rx_is_mrd;
  wire root_mode;
  wire vsec_on;
  wire d3_to_d0;

  assign byte_adr = {i_wb_adr[7:2], 2'b00};
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign rx_type = i_rx_dw0[`PAC_F_TYPE];
  assign rx_is_msg = (rx_type[4:3] == `PAC_MSG_HI);
  assign rx_is_mrd = (rx_type == `PAC_T_MRD) | (rx_type == `PAC_T_MRDLK);
  assign root_mode = ctrl_r[`PAC_B_ROOT];
  assign vsec_on = ctrl_r[`PAC_B_VSEC] & ctrl_r[`PAC_B_DSN];
  assign d3_to_d0 = (pm_prev_r == `PAC_D3) & (i_pm_state == `PAC_D0);

  // byte lane merge for a write
  function [31:0] lane_mrg;
    input [31:0] old;
    input [31:0] neu;
    input [3:0] sel;
    integer k;
    begin
      lane_mrg = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_mrg[k*8 +: 8] = neu[k*8 +: 8];
        end
      end
    end
  endfunction

  // built-in timer grows with payload size and shrinks with width
  function [14:0] tmr_table;
    input [14:0] base;
    input [2:0] mps;
    input [3:0] wid;
    reg [14:0] t;
    begin
      t = base << mps;
      case (wid)
        4'h2: tmr_table = t >> 1;
        4'h4: tmr_table = t >> 2;
        4'h8: tmr_table = t >> 3;
        default: tmr_table = t;
      endcase
    end
  endfunction

  // override combine; add and subtract wrap at 15 bits by design
  function [14:0] tmr_mix;
    input [14:0] builtin;
    input [18:0] ovr;
    begin
      if (!ovr[18]) begin
        tmr_mix = builtin;
      end else begin
        case (ovr[17:16])
          `PAC_FN_ABS: tmr_mix = ovr[14:0];
          `PAC_FN_ADD: tmr_mix = builtin + ovr[14:0];
          `PAC_FN_SUB: tmr_mix = builtin - ovr[14:0];
          default: tmr_mix = builtin;
        endcase
      end
    end
  endfunction

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (byte_adr)
      `PAC_A_CTRL: rd_nxt = ctrl_r;
      `PAC_A_PMCAP: begin
        rd_nxt[`PAC_B_DSI] = ctrl_r[`PAC_B_DSI];
        rd_nxt[`PAC_B_D1] = ctrl_r[`PAC_B_D1];
        rd_nxt[`PAC_B_D2] = ctrl_r[`PAC_B_D2];
        rd_nxt[`PAC_F_PME] = ctrl_r[`PAC_F_PME];
        rd_nxt[23:16] = `PAC_ZERO_W;
        rd_nxt[31:24] = `PAC_ZERO_W;
      end
      `PAC_A_LEGPTR: rd_nxt[5:0] = leg_ptr_r;
      `PAC_A_EXTPTR: rd_nxt[9:0] = ext_ptr_r;
      `PAC_A_ACKOVR: rd_nxt[18:0] = ack_ovr_r;
      `PAC_A_RPLOVR: rd_nxt[18:0] = rpl_ovr_r;
      `PAC_A_TMR: rd_nxt = {1'b0, o_replay_timeout, 1'b0, o_ack_timeout};
      `PAC_A_LINK: rd_nxt[7:0] = link_num_r;
      `PAC_A_DSNLO: begin
        if (ctrl_r[`PAC_B_DSN]) begin
          rd_nxt = i_dsn[31:0];
        end
      end
      `PAC_A_DSNHI: begin
        if (ctrl_r[`PAC_B_DSN]) begin
          rd_nxt = i_dsn[63:32];
        end
      end
      `PAC_A_STAT: rd_nxt[4:0] = {o_dsi_seq_req, vsec_on, o_vc_cap_present, i_pm_state};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @* begin
    wr_nxt = lane_mrg(ctrl_r, i_wb_dat, i_wb_sel) & `PAC_CTRL_MASK;
    if (!(wr_nxt[`PAC_B_VSEC] & wr_nxt[`PAC_B_DSN])) begin
      wr_nxt[`PAC_B_LOOP] = 1'b0;
    end
    leg_nxt = i_wb_sel[0] ? i_wb_dat[5:0] : leg_ptr_r;
    if (leg_nxt < `PAC_LEG_MIN) begin
      leg_nxt = `PAC_LEG_MIN;
    end
    ext_mrg = lane_mrg({22'h0, ext_ptr_r}, i_wb_dat, i_wb_sel);
    ext_nxt = ext_mrg[9:0];
    ack_mrg = lane_mrg({13'h0, ack_ovr_r}, i_wb_dat, i_wb_sel);
    rpl_mrg = lane_mrg({13'h0, rpl_ovr_r}, i_wb_dat, i_wb_sel);
    if (ext_nxt < `PAC_EXT_MIN) begin
      ext_nxt = `PAC_EXT_MIN;
    end
  end

  // one wait state: ack follows the request by one edge
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      ctrl_r <= `PAC_CTRL_RST;
      leg_ptr_r <= `PAC_LEG_MIN;
      ext_ptr_r <= `PAC_EXT_RST;
      ack_ovr_r <= 19'h0_0000;
      rpl_ovr_r <= 19'h0_0000;
      link_num_r <= 8'h00;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_nxt : 32'h0000_0000;
      if (wb_req && i_wb_we) begin
        case (byte_adr)
          `PAC_A_CTRL: ctrl_r <= wr_nxt;
          `PAC_A_LEGPTR: leg_ptr_r <= leg_nxt;
          `PAC_A_EXTPTR: ext_ptr_r <= ext_nxt[9:0];
          `PAC_A_ACKOVR: begin
            ack_ovr_r <= ack_mrg[18:0] & 19'h7_7FFF;
          end
          `PAC_A_RPLOVR: begin
            rpl_ovr_r <= rpl_mrg[18:0] & 19'h7_7FFF;
          end
          `PAC_A_LINK: begin
            if (i_wb_sel[0]) begin
              link_num_r <= i_wb_dat[7:0];
            end
          end
          default: link_num_r <= link_num_r;
        endcase
      end
    end
  end

  // wake allowed only in states the function supports
  always @* begin
    case (i_pm_state)
      `PAC_D0: pme_ok = ctrl_r[3];
      `PAC_D1: pme_ok = ctrl_r[4] & ctrl_r[`PAC_B_D1];
      `PAC_D2: pme_ok = ctrl_r[5] & ctrl_r[`PAC_B_D2];
      `PAC_D3: pme_ok = ctrl_r[6] | ctrl_r[7];
      default: pme_ok = 1'b0;
    endcase
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pm_prev_r <= `PAC_D0;
      o_power_wake_request_out <= 1'b0;
      o_pm_internal_rst <= 1'b0;
      o_dsi_seq_req <= 1'b0;
      o_power_budget <= `PAC_ZERO_W;
      o_power_dissipated <= `PAC_ZERO_W;
    end else begin
      pm_prev_r <= i_pm_state;
      o_power_wake_request_out <= i_pme_req & pme_ok;
      // context is never kept: the soft reset option does not exist
      o_pm_internal_rst <= d3_to_d0;
      // set wins over the done strobe so a fresh entry is never lost
      if (d3_to_d0 && ctrl_r[`PAC_B_DSI]) begin
        o_dsi_seq_req <= 1'b1;
      end else if (i_dsi_done) begin
        o_dsi_seq_req <= 1'b0;
      end
      o_power_budget <= `PAC_ZERO_W;
      o_power_dissipated <= `PAC_ZERO_W;
    end
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dsn_cap_present <= 1'b0;
      o_vc_cap_present <= 1'b0;
      o_vsec_cap_present <= 1'b0;
      o_loopback_en <= 1'b0;
    end else begin
      o_dsn_cap_present <= ctrl_r[`PAC_B_DSN];
      o_vc_cap_present <= ctrl_r[`PAC_B_VC] & ctrl_r[`PAC_B_DSN];
      o_vsec_cap_present <= vsec_on;
      o_loopback_en <= vsec_on & ctrl_r[`PAC_B_LOOP];
    end
  end

  // config routing: below legacy pointer the core answers itself
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_vld <= 1'b0;
      o_cfg_to_user <= 1'b0;
    end else begin
      o_cfg_vld <= i_cfg_vld;
      o_cfg_to_user <= 1'b0;
      if (i_cfg_vld) begin
        if (i_cfg_dw_addr < `PAC_EXT_MIN) begin
          o_cfg_to_user <= ctrl_r[`PAC_B_LEGEN] & ~root_mode &
                           (i_cfg_dw_addr[5:0] >= leg_ptr_r);
        end else begin
          o_cfg_to_user <= ctrl_r[`PAC_B_EXTEN] & ~root_mode &
                           (i_cfg_dw_addr >= ext_ptr_r);
        end
      end
    end
  end

  always @* begin
    msg_pass = 1'b0;
    if (ctrl_r[`PAC_B_MSGRT]) begin
      if (!root_mode) begin
        msg_pass = (i_rx_msg_code == `PAC_M_UNLOCK) |
                   (i_rx_msg_code == `PAC_M_TURNOFF);
      end else begin
        msg_pass = (i_rx_msg_code == `PAC_M_ERRCOR) |
                   (i_rx_msg_code == `PAC_M_ERRNF) |
                   (i_rx_msg_code == `PAC_M_ERRF) |
                   ((i_rx_msg_code >= `PAC_M_INT_LO) &
                    (i_rx_msg_code <= `PAC_M_INT_HI)) |
                   (i_rx_msg_code == `PAC_M_PM_PME) |
                   (i_rx_msg_code == `PAC_M_TOACK);
      end
    end
  end

  // header side of inbound packets; payload is not touched here
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_vld <= 1'b0;
      o_rx_dw0 <= 32'h0000_0000;
      o_rx_len_dw <= 11'h000;
      o_rx_deliver <= 1'b0;
      o_rx_ur <= 1'b0;
    end else begin
      o_rx_vld <= i_rx_vld;
      o_rx_dw0 <= i_rx_dw0;
      o_rx_len_dw <= i_rx_len_dw;
      if (ctrl_r[`PAC_B_TRIM] && i_rx_dw0[`PAC_B_TD]) begin
        o_rx_dw0[`PAC_B_TD] <= 1'b0;
        o_rx_len_dw <= i_rx_len_dw - 11'h001;
      end
      o_rx_ur <= i_rx_vld & root_mode & ctrl_r[`PAC_B_REJSN] &
                 rx_is_mrd & ~i_rx_dw0[`PAC_B_NS];
      o_rx_deliver <= i_rx_vld & (~rx_is_msg | msg_pass);
    end
  end

  always @* begin
    ack_base = tmr_table(`PAC_ACK_BASE, i_mps, i_neg_width);
    rpl_base = tmr_table(`PAC_RPL_BASE, i_mps, i_neg_width);
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack_timeout <= `PAC_ACK_BASE;
      o_replay_timeout <= `PAC_RPL_BASE;
      o_buf_wr_pipe <= 1'b0;
      o_buf_rd_pipe <= 1'b0;
    end else begin
      o_ack_timeout <= tmr_mix(ack_base, ack_ovr_r);
      // software must keep the sum inside 15 bits
      o_replay_timeout <= tmr_mix(rpl_base, rpl_ovr_r);
      o_buf_wr_pipe <= (ctrl_r[`PAC_F_PIPE] != 2'h0);
      o_buf_rd_pipe <= (ctrl_r[`PAC_F_PIPE] > `PAC_PIPE_WR);
    end
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lane_rev_en <= 1'b0;
      o_scramble_dis <= 1'b0;
      o_upcfg_capable <= 1'b0;
      o_tx_l0s_enter <= 1'b0;
      o_ts_link_num <= 8'h00;
      o_ts_link_num_vld <= 1'b0;
    end else begin
      o_lane_rev_en <= ctrl_r[`PAC_B_LREV];
      o_scramble_dis <= ctrl_r[`PAC_B_NOSCR];
      o_upcfg_capable <= ctrl_r[`PAC_B_UPCFG];
      o_tx_l0s_enter <= i_tx_l0s_req & ~ctrl_r[`PAC_B_L0SDIS];
      // upstream ports send pad, so the number is flagged invalid there
      o_ts_link_num <= link_num_r;
      o_ts_link_num_vld <= ctrl_r[`PAC_B_DOWN];
    end
  end

endmodule

//--- verif/pac_attr_ctrl_checker.sv
`timescale 1ns/10ps
module pac_attr_ctrl_checker (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [1:0] i_pm_state,
  input wire i_pme_req,
  input wire o_power_wake_request_out,
  input wire o_pm_internal_rst,
  input wire [7:0] o_power_budget,
  input wire [7:0] o_power_dissipated,
  input wire o_dsn_cap_present,
  input wire o_vc_cap_present,
  input wire o_vsec_cap_present,
  input wire o_loopback_en,
  input wire i_cfg_vld,
  input wire o_cfg_vld,
  input wire o_cfg_to_user,
  input wire [31:0] i_rx_dw0,
  input wire [10:0] i_rx_len_dw,
  input wire o_rx_vld,
  input wire [31:0] o_rx_dw0,
  input wire [10:0] o_rx_len_dw,
  input wire o_rx_ur
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_ZERO_BUDGET: assert property (o_power_budget == 8'h00)
    else $error("power budget is not zero");
  AST_ZERO_DISS: assert property (o_power_dissipated == 8'h00)
    else $error("power dissipation is not zero");
  AST_WAKE_CAUSE: assert property (o_power_wake_request_out |-> $past(i_pme_req))
    else $error("wake pulse without a wake request");
  AST_D3_RESET: assert property ($past(i_pm_state) == 2'h3 && i_pm_state == 2'h0 |-> ##[1:2] o_pm_internal_rst)
    else $error("no internal reset after leaving D3hot");
  AST_CAP_DEP: assert property (o_vc_cap_present || o_vsec_cap_present |-> o_dsn_cap_present)
    else $error("extended capability without serial number");
  AST_LOOP_DEP: assert property (o_loopback_en |-> o_vsec_cap_present)
    else $error("loopback control without vendor capability");
  AST_CFG_ANS: assert property (i_cfg_vld |=> o_cfg_vld)
    else $error("config request not answered");
  AST_CFG_USER: assert property (o_cfg_to_user |-> o_cfg_vld)
    else $error("user routing without a request");
  AST_UR_CLEAR: assert property (o_rx_ur |-> o_rx_vld && !o_rx_dw0[12])
    else $error("unsupported request on a snoop-clear header");
  AST_TRIM_LEN: assert property (o_rx_vld && $past(i_rx_dw0[15]) && !o_rx_dw0[15] |-> o_rx_len_dw == $past(i_rx_len_dw) - 11'h001)
    else $error("digest cleared but length not trimmed");
endmodule

//--- verif/pac_user_model.sv
`timescale 1ns/10ps
module pac_user_model (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_dsi_req,
  input wire i_slow,
  output logic [63:0] o_dsn,
  output logic o_dsi_done
);
  logic [3:0] cnt_r;
  // serial value is arbitrary
  assign o_dsn = 64'h0123_4567_89AB_CDEF;
  // init sequence takes 2 or 9 cycles, so both prompt and slow answers are seen
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 4'h0;
      o_dsi_done <= 1'h0;
    end else begin
      o_dsi_done <= 1'h0;
      if (!i_dsi_req || o_dsi_done) cnt_r <= 4'h0;
      else if (cnt_r == (i_slow ? 4'h8 : 4'h1)) o_dsi_done <= 1'h1;
      else cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

//--- verif/pac_attr_ctrl_tb.sv
`timescale 1ns/10ps
module pac_attr_ctrl_tb;
  logic i_sys_clk = 0, i_rst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0, i_pme_req = 0;
  logic i_cfg_vld = 0, i_rx_vld = 0, i_tx_l0s_req = 0, slow = 0;
  logic [7:0] i_wb_adr = 8'h00, i_rx_msg_code = 8'h00;
  logic [3:0] i_wb_sel = 4'hF, i_neg_width = 4'h1;
  logic [31:0] i_wb_dat = 32'h0, i_rx_dw0 = 32'h0, q;
  logic [1:0] i_pm_state = 2'h0;
  logic [2:0] i_mps = 3'h0;
  logic [9:0] i_cfg_dw_addr = 10'h000;
  logic [10:0] i_rx_len_dw = 11'h000;
  wire [63:0] i_dsn;
  wire [31:0] o_wb_dat, o_rx_dw0;
  wire [14:0] o_ack_timeout, o_replay_timeout;
  wire [10:0] o_rx_len_dw;
  wire [7:0] o_power_budget, o_power_dissipated, o_ts_link_num;
  wire i_dsi_done, o_wb_ack, o_power_wake_request_out, o_pm_internal_rst, o_dsi_seq_req;
  wire o_dsn_cap_present, o_vc_cap_present, o_vsec_cap_present, o_loopback_en, o_cfg_vld;
  wire o_cfg_to_user, o_rx_vld, o_rx_deliver, o_rx_ur, o_buf_wr_pipe, o_buf_rd_pipe;
  wire o_lane_rev_en, o_scramble_dis, o_upcfg_capable, o_tx_l0s_enter, o_ts_link_num_vld;
  int n_fail = 0, checks_done = 0;
  logic [7:0] codes[9] = '{8'h00, 8'h19, 8'h30, 8'h31, 8'h33, 8'h20, 8'h27, 8'h18, 8'h1B};
  // override values keep every result inside 15 bits
  logic [14:0] ov[3] = '{15'h0100, 15'h0010, 15'h0001};
  logic [14:0] ea[3] = '{15'h0100, 15'h0031, 15'h0020};
  logic [14:0] er[3] = '{15'h0100, 15'h0074, 15'h0063};

  always #10 i_sys_clk = ~i_sys_clk;
  pac_attr_ctrl pac_attr_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_dsn(i_dsn), .i_pm_state(i_pm_state), .i_pme_req(i_pme_req), .i_dsi_done(i_dsi_done),
    .o_power_wake_request_out(o_power_wake_request_out), .o_pm_internal_rst(o_pm_internal_rst),
    .o_dsi_seq_req(o_dsi_seq_req), .o_power_budget(o_power_budget), .o_power_dissipated(o_power_dissipated),
    .o_dsn_cap_present(o_dsn_cap_present), .o_vc_cap_present(o_vc_cap_present),
    .o_vsec_cap_present(o_vsec_cap_present), .o_loopback_en(o_loopback_en), .i_cfg_vld(i_cfg_vld),
    .i_cfg_dw_addr(i_cfg_dw_addr), .o_cfg_vld(o_cfg_vld), .o_cfg_to_user(o_cfg_to_user), .i_rx_vld(i_rx_vld),
    .i_rx_dw0(i_rx_dw0), .i_rx_msg_code(i_rx_msg_code), .i_rx_len_dw(i_rx_len_dw), .o_rx_vld(o_rx_vld),
    .o_rx_dw0(o_rx_dw0), .o_rx_len_dw(o_rx_len_dw), .o_rx_deliver(o_rx_deliver), .o_rx_ur(o_rx_ur),
    .o_buf_wr_pipe(o_buf_wr_pipe), .o_buf_rd_pipe(o_buf_rd_pipe), .i_neg_width(i_neg_width), .i_mps(i_mps),
    .o_ack_timeout(o_ack_timeout), .o_replay_timeout(o_replay_timeout), .o_lane_rev_en(o_lane_rev_en),
    .o_scramble_dis(o_scramble_dis), .o_upcfg_capable(o_upcfg_capable), .i_tx_l0s_req(i_tx_l0s_req),
    .o_tx_l0s_enter(o_tx_l0s_enter), .o_ts_link_num(o_ts_link_num), .o_ts_link_num_vld(o_ts_link_num_vld));
  pac_user_model pac_user_model_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_dsi_req(o_dsi_seq_req),
    .i_slow(slow), .o_dsn(i_dsn), .o_dsi_done(i_dsi_done));

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task fin(input string s);
    $display("end of %s test, mismatches so far %0d", s, n_fail);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'h1 && n < 20);
    q = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    if (n == 20) chk(32'h0, 32'h1);
    repeat (2) @(posedge i_sys_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task cfg(input logic [9:0] a, input logic e);
    @(posedge i_sys_clk);
    i_cfg_vld <= 1'h1;
    i_cfg_dw_addr <= a;
    @(posedge i_sys_clk);
    i_cfg_vld <= 1'h0;
    @(posedge i_sys_clk);
    chk({o_cfg_vld, o_cfg_to_user}, {1'h1, e});
  endtask
  task rx(input logic [31:0] d, input logic [7:0] c);
    @(posedge i_sys_clk);
    i_rx_vld <= 1'h1;
    i_rx_dw0 <= d;
    i_rx_msg_code <= c;
    i_rx_len_dw <= 11'h005;
    @(posedge i_sys_clk);
    i_rx_vld <= 1'h0;
    @(posedge i_sys_clk);
  endtask

  task t_pm;
    rd(8'h00, 32'h0040_0000);
    chk(o_upcfg_capable, 1'h1);
    wb(1'h1, 8'h00, 32'h0000_0107);
    rd(8'h04, 32'h0000_0007);
    rd(8'h00, 32'h0000_0007);
    wb(1'h1, 8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    chk({o_power_budget, o_power_dissipated}, 32'h0);
    fin("pm");
  endtask
  task t_wake;
    for (int k = 0; k < 2; k++) begin
      wb(1'h1, 8'h00, k ? 32'h0000_0056 : 32'h0000_002E);
      rd(8'h04, k ? 32'h0000_0056 : 32'h0000_002E);
      for (int s = 0; s < 4; s++) begin
        @(posedge i_sys_clk);
        i_pm_state <= s[1:0];
        i_pme_req <= 1'h1;
        @(posedge i_sys_clk);
        i_pme_req <= 1'h0;
        @(posedge i_sys_clk);
        chk(o_power_wake_request_out, (s % 2) == k);
      end
    end
    fin("wake");
  endtask
  task t_d3;
    int n;
    wb(1'h1, 8'h00, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      slow <= k[0];
      i_pm_state <= 2'h3;
      repeat (3) @(posedge i_sys_clk);
      i_pm_state <= 2'h0;
      n = 0;
      repeat (4) begin
        @(posedge i_sys_clk);
        n += o_pm_internal_rst;
      end
      chk(n, 1);
      if (k) chk(o_dsi_seq_req, 1'h1);
      if (k) rd(8'h28, 32'h0000_0010);
      repeat (20) @(posedge i_sys_clk);
      chk(o_dsi_seq_req, 1'h0);
    end
    fin("d3");
  endtask
  task t_dsn;
    wb(1'h1, 8'h00, 32'h0200_0E00);
    chk({o_dsn_cap_present, o_vc_cap_present, o_vsec_cap_present, o_loopback_en}, 4'hF);
    rd(8'h20, 32'h89AB_CDEF);
    rd(8'h24, 32'h0123_4567);
    wb(1'h1, 8'h00, 32'h0200_0C00);
    chk({o_dsn_cap_present, o_vc_cap_present, o_vsec_cap_present, o_loopback_en}, 4'h0);
    fin("dsn");
  endtask
  task t_cfg;
    rd(8'h0C, 32'h0000_0100);
    wb(1'h1, 8'h08, 32'h0000_0010);
    rd(8'h08, 32'h0000_002A);
    wb(1'h1, 8'h08, 32'h0000_003F);
    rd(8'h08, 32'h0000_003F);
    wb(1'h1, 8'h00, 32'h0000_C000);
    cfg(10'h03E, 1'h0);
    cfg(10'h03F, 1'h1);
    cfg(10'h0FF, 1'h0);
    cfg(10'h100, 1'h1);
    wb(1'h1, 8'h00, 32'h0000_0000);
    cfg(10'h03F, 1'h0);
    fin("cfg");
  endtask
  task t_rx;
    wb(1'h1, 8'h00, 32'h0001_0000);
    rx(32'h4000_8004, 8'h00);
    chk(o_rx_dw0, 32'h4000_0004);
    chk({o_rx_vld, o_rx_deliver, o_rx_len_dw}, {1'h1, 1'h1, 11'h004});
    for (int m = 0; m < 3; m++) begin
      wb(1'h1, 8'h00, m == 0 ? 32'h0002_0000 : m == 1 ? 32'h0002_1000 : 32'h0);
      for (int i = 0; i < 9; i++) begin
        rx(32'h3000_0000, codes[i]);
        chk(o_rx_deliver, m == 2 ? 1'h0 : (i < 2) == (m == 0));
      end
    end
    wb(1'h1, 8'h00, 32'h0000_3000);
    rx(32'h0000_0001, 8'h00);
    chk(o_rx_ur, 1'h1);
    rx(32'h0000_1001, 8'h00);
    chk(o_rx_ur, 1'h0);
    fin("rx");
  endtask
  task t_tmr;
    for (int t = 0; t < 3; t++) begin
      wb(1'h1, 8'h10, 32'h0004_0000 | (t << 16) | ov[t]);
      wb(1'h1, 8'h14, 32'h0004_0000 | (t << 16) | ov[t]);
      chk(o_ack_timeout, ea[t]);
      chk(o_replay_timeout, er[t]);
    end
    wb(1'h1, 8'h10, 32'h0);
    wb(1'h1, 8'h14, 32'h0);
    i_neg_width <= 4'h2;
    repeat (2) @(posedge i_sys_clk);
    chk({o_ack_timeout, o_replay_timeout}, {15'h0010, 15'h0032});
    i_neg_width <= 4'h1;
    i_mps <= 3'h2;
    repeat (2) @(posedge i_sys_clk);
    chk({o_ack_timeout, o_replay_timeout}, {15'h0084, 15'h0190});
    rd(8'h18, 32'h0190_0084);
    i_mps <= 3'h0;
    fin("timer");
  endtask
  task t_phy;
    for (int p = 0; p < 4; p++) begin
      wb(1'h1, 8'h00, p << 18);
      chk({o_buf_wr_pipe, o_buf_rd_pipe}, p == 0 ? 2'h0 : p == 1 ? 2'h2 : 2'h3);
    end
    chk(o_upcfg_capable, 1'h0);
    i_tx_l0s_req <= 1'h1;
    wb(1'h1, 8'h1C, 32'h0000_005A);
    rd(8'h1C, 32'h0000_005A);
    wb(1'h1, 8'h00, 32'h01B0_0000);
    chk({o_lane_rev_en, o_scramble_dis, o_upcfg_capable, o_tx_l0s_enter, o_ts_link_num_vld}, 5'h19);
    chk(o_ts_link_num, 8'h5A);
    wb(1'h1, 8'h00, 32'h0000_0000);
    chk({o_lane_rev_en, o_scramble_dis, o_tx_l0s_enter, o_ts_link_num_vld}, 4'h2);
    fin("phy");
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    t_pm;
    t_wake;
    t_d3;
    t_dsn;
    t_cfg;
    t_rx;
    t_tmr;
    t_phy;
    test_done;
  end
  // whole run needs about 420 cycles; the limit leaves ample margin
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
endmodule
bind pac_attr_ctrl pac_attr_ctrl_checker pac_attr_ctrl_checker_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_pm_state(i_pm_state), .i_pme_req(i_pme_req), .o_power_wake_request_out(o_power_wake_request_out),
  .o_pm_internal_rst(o_pm_internal_rst), .o_power_budget(o_power_budget), .o_power_dissipated(o_power_dissipated),
  .o_dsn_cap_present(o_dsn_cap_present), .o_vc_cap_present(o_vc_cap_present),
  .o_vsec_cap_present(o_vsec_cap_present), .o_loopback_en(o_loopback_en), .i_cfg_vld(i_cfg_vld),
  .o_cfg_vld(o_cfg_vld), .o_cfg_to_user(o_cfg_to_user), .i_rx_dw0(i_rx_dw0), .i_rx_len_dw(i_rx_len_dw),
  .o_rx_vld(o_rx_vld), .o_rx_dw0(o_rx_dw0), .o_rx_len_dw(o_rx_len_dw), .o_rx_ur(o_rx_ur));
